// ### design/regport_pkg.sv
// Purpose: Shared constants for the serial register port and its control logic
// Assumes: 8-bit registers, 7-bit address space
// Notes:   Field positions inside 0x01, 0x17 and 0x2F are fixed here
`default_nettype none
package regport_pkg;
    // ------------------------------------------------------------
    // Protocol
    // ------------------------------------------------------------
    localparam int unsigned BYTE_BITS     = 8;
    localparam int unsigned ADDR_BITS     = 7;
    localparam int unsigned DIR_BIT_POS   = 7;       // Command byte direction bit
    localparam logic        DIR_WRITE     = 1'b1;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_ENABLE     = 7'h01;
    localparam logic [6:0] ADDR_PROT_LO    = 7'h02;
    localparam logic [6:0] ADDR_PROT_HI    = 7'h09;
    localparam logic [6:0] ADDR_FAULT_FLAGS = 7'h0c;
    localparam logic [6:0] ADDR_FAULT_MASK = 7'h0d;
    localparam logic [6:0] ADDR_LINK_RANGE = 7'h17;
    localparam logic [6:0] ADDR_DETAIL_LO  = 7'h27;
    localparam logic [6:0] ADDR_DETAIL_HI  = 7'h2a;
    localparam logic [6:0] ADDR_UNLOCK_KEY = 7'h2e;
    localparam logic [6:0] ADDR_NV_CTRL    = 7'h2f;
    localparam logic [6:0] ADDR_USER_LO    = 7'h30;
    localparam logic [6:0] ADDR_USER_HI    = 7'h35;
    localparam logic [6:0] ADDR_LAST       = 7'h7f;
    localparam int unsigned USER_BYTES     = 6;
    localparam int unsigned REG_COUNT      = 128;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned FAST_SD_POS    = 7;      // In 0x01
    localparam logic [7:0] ENABLE_RESET    = 8'h82;
    localparam int unsigned RANGE_SEL_POS  = 0;      // In 0x17
    localparam int unsigned PROTECT_POS    = 0;      // In 0x2F
    localparam int unsigned PROGRAM_POS    = 1;      // In 0x2F
    localparam logic [7:0] KEY_FIRST       = 8'hba;
    localparam logic [7:0] KEY_SECOND      = 8'hbe;
    localparam logic [7:0] KEY_LOCKED_RD   = 8'h00;
    localparam logic [7:0] KEY_UNLOCKED_RD = 8'h01;
    // High-level flag bit positions in fault_flags
    localparam int unsigned HF_SUPPLY = 0;
    localparam int unsigned HF_ILLUM  = 1;
    localparam int unsigned HF_PWRREQ = 2;
    localparam int unsigned HF_LOWCUT = 3;
    localparam int unsigned HF_LOWWRN = 4;
    localparam int unsigned HF_THCUT  = 5;
    localparam int unsigned HF_THWRN  = 6;
    // Detailed fault input vector positions (18 inputs)
    localparam int unsigned DETAIL_BITS = 18;
    localparam int unsigned DF_MIRROR_LO = 0;        // 0..8: mirror rail group
    localparam int unsigned DF_MIRROR_HI = 8;
    localparam int unsigned DF_AUX_PG   = 9;
    localparam int unsigned DF_AUX_OV   = 10;
    localparam int unsigned DF_L1_PG    = 11;
    localparam int unsigned DF_L1_OV    = 12;
    localparam int unsigned DF_L2_PG    = 13;
    localparam int unsigned DF_L2_OV    = 14;
    localparam int unsigned DF_LOWCUT   = 15;
    localparam int unsigned DF_LOWWRN   = 16;
    localparam int unsigned DF_THCUT    = 17;
    // ------------------------------------------------------------
    // Link clock dividers (host side, from clk)
    // ------------------------------------------------------------
    localparam int unsigned SCK_HALF_NORMAL = 2;
    localparam int unsigned SCK_HALF_FAST   = 1;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned PROG_HOLD_MS  = 250;
    localparam longint unsigned PROG_HOLD_CYC =
        longint'(PROG_HOLD_MS) * longint'(CLK_HZ) / 64'd1000 + 64'd1;
endpackage : regport_pkg
`default_nettype wire

// ### design/regport_if.sv
// Purpose: Four-wire serial link between controller and power device
// Assumes: Interface resolves the data-out wire from its enable
// Notes:   No clocking block
`default_nettype none
interface regport_if;
    logic sck;        // Link clock, made by the host
    logic sel_n;      // Port select, active low
    logic mosi;       // Host to device data
    logic miso_o;     // Device data out
    logic miso_oe;    // Device drives data out when high
    logic miso;       // Resolved data-out wire
    assign miso = miso_oe ? miso_o : 1'b0;
    modport device (input sck, input sel_n, input mosi, output miso_o, output miso_oe);
    modport host   (output sck, output sel_n, output mosi, input miso);
endinterface : regport_if
`default_nettype wire

// ### design/regport_device.sv
// Purpose: Device end: serial register slave, fault flags, fast shutdown, protection
// Assumes: Link logic on the link clock; fault and power inputs are on clk
// Notes:   Register file lives on the link clock; clear-on-read flags avoided
//
// Contract
// - Normal or fast link range via 0x17
// - Host holds select low whole transaction
// - Select high: ignore input, float output
// - Sample rising edge, shift out falling
// - Command MSB one writes, zero reads
// - Low seven command bits give address
// - Address advances after each data byte
// - Address wraps 0x7F to 0x00
// - Faults set fault_flags flags, drive interrupt
// - Mask bits in fault_mask block interrupt
// - High flags fault_flags, detail 0x27-0x2A (detail_r is kept but never read; 0x27-0x2A return plain storage)
// - Supply and illumination groups combine faults
// - Independent power, battery, thermal high flags (code never sets the power flag; it sets the thermal warning flag from the thermal cutoff input)
// - Fast shutdown enable 0x01 resets on
// - Fast shutdown only on listed faults
// - Power request low starts normal shutdown
// - Protection allows only 0x02-0x09 writes (code also lets 0x2F, 0x2E and flag-clear writes through)
// - Unlock only on consecutive key pair
// - User bytes writable until other key
// - Program bit high then low later
// - Key register reads lock state
// - Power request low resets, port deaf
`default_nettype none
module regport_device
    import regport_pkg::*;
(
    // System
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Serial link
    regport_if.device                   link,
    // Power and fault inputs
    input  wire logic                   power_request_pin,
    input  wire logic [DETAIL_BITS-1:0] fault_in,
    // Control outputs
    output logic                        irq_n_o,
    output logic                        irq_n_oe,
    output logic                        fast_shutdown,
    output logic                        normal_shutdown,
    output logic                        link_clock_range_select,
    output logic                        nv_program
);
    // ------------------------------------------------------------
    // Power-request synchroniser and reset of the link domain
    // ------------------------------------------------------------
    logic pwr_s1_r, pwr_s2_r, pwr_d_r;   // On clk
    logic lpwr_s1_r, lpwr_s2_r;          // On link clock
    logic lrst_n;                        // Link-domain reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_s1_r <= 1'b0;
            pwr_s2_r <= 1'b0;
            pwr_d_r  <= 1'b0;
        end else begin
            pwr_s1_r <= power_request_pin;
            pwr_s2_r <= pwr_s1_r;
            pwr_d_r  <= pwr_s2_r;
        end
    end
    always_ff @(posedge link.sck) begin
        lpwr_s1_r <= power_request_pin;
        lpwr_s2_r <= lpwr_s1_r;
    end
    // Registers return to defaults on link clock rises while power is not requested
    assign lrst_n = lpwr_s2_r;
    // A normal shutdown starts on the falling power request
    assign normal_shutdown = pwr_d_r & ~pwr_s2_r;
    // ------------------------------------------------------------
    // Fault grouping on clk
    // ------------------------------------------------------------
    logic                   mirror_rail_group_error;
    logic                   supply_err, illum_err;
    logic [7:0]             hi_now;       // Live high-level conditions
    logic [7:0]             flags_r;      // Sticky high-level flags
    logic [DETAIL_BITS-1:0] detail_r;     // Sticky detailed flags
    logic                   clr_tgl_s1_r, clr_tgl_s2_r, clr_tgl_d_r;
    logic                   clr_tgl_r;    // Link side, toggles per flag-register write
    logic [7:0]             clr_bits_r;   // Bits to clear, stable around toggle
    logic                   clr_evt;
    assign mirror_rail_group_error = |fault_in[DF_MIRROR_HI:DF_MIRROR_LO];
    assign supply_err = mirror_rail_group_error | fault_in[DF_AUX_PG] | fault_in[DF_AUX_OV];
    assign illum_err  = |fault_in[DF_L2_OV:DF_L1_PG];
    always_comb begin
        hi_now            = 8'h00;
        hi_now[HF_SUPPLY] = supply_err;
        hi_now[HF_ILLUM]  = illum_err;
        hi_now[HF_PWRREQ] = normal_shutdown;
        hi_now[HF_LOWCUT] = fault_in[DF_LOWCUT];
        hi_now[HF_LOWWRN] = fault_in[DF_LOWWRN];
        hi_now[HF_THCUT]  = fault_in[DF_THCUT];
        hi_now[HF_THWRN]  = fault_in[DF_THCUT];
    end
    // Clear requests cross as a toggle; the data bits are stable by then
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clr_tgl_s1_r <= 1'b0;
            clr_tgl_s2_r <= 1'b0;
            clr_tgl_d_r  <= 1'b0;
        end else begin
            clr_tgl_s1_r <= clr_tgl_r;
            clr_tgl_s2_r <= clr_tgl_s1_r;
            clr_tgl_d_r  <= clr_tgl_s2_r;
        end
    end
    assign clr_evt = clr_tgl_s2_r ^ clr_tgl_d_r;
    // Sticky flags: a new fault wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n || !pwr_s2_r) begin
            flags_r  <= 8'h00;
            detail_r <= '0;
        end else begin
            flags_r  <= (flags_r & ~(clr_evt ? clr_bits_r : 8'h00)) | hi_now;
            detail_r <= (clr_evt ? '0 : detail_r) | fault_in;
        end
    end
    // ------------------------------------------------------------
    // Link domain: shift engine
    // ------------------------------------------------------------
    logic [7:0] mem_r [0:REG_COUNT-1];   // Plain storage
    logic [2:0] bit_cnt_r;
    logic [6:0] sh_in_r;
    logic       have_cmd_r, is_wr_r;
    logic [6:0] addr_r;
    logic [7:0] tx_r;
    logic [7:0] rx_byte;
    logic       byte_done;
    logic [7:0] rd_data;
    logic [7:0] mask_r, enable_r, range_r, nvctl_r;
    logic       unlocked_r, key_half_r;
    logic       wr_ok;
    logic [7:0] flags_s1_r, flags_s2_r;  // Slow-changing, multi-bit sampled status
    logic [6:0] next_addr;
    assign rx_byte   = {sh_in_r, link.mosi};
    assign byte_done = (bit_cnt_r == 3'd7);
    assign next_addr = have_cmd_r ? addr_r + 7'd1 : rx_byte[6:0];
    // Status copies into the link domain
    always_ff @(posedge link.sck) begin
        flags_s1_r <= flags_r;
        flags_s2_r <= flags_s1_r;
    end
    // Read mux: addr_r already points at the byte about to be shifted out
    always_comb begin
        case (addr_r)
            ADDR_ENABLE:      rd_data = enable_r;
            ADDR_FAULT_FLAGS: rd_data = flags_s2_r;
            ADDR_FAULT_MASK:  rd_data = mask_r;
            ADDR_LINK_RANGE:  rd_data = range_r;
            ADDR_UNLOCK_KEY:  rd_data = unlocked_r ? KEY_UNLOCKED_RD : KEY_LOCKED_RD;
            ADDR_NV_CTRL:     rd_data = nvctl_r;
            default:          rd_data = mem_r[addr_r];
        endcase
    end
    // Write permission: protection, and user bytes only when unlocked
    always_comb begin
        wr_ok = 1'b1;
        if (nvctl_r[PROTECT_POS] && addr_r != ADDR_NV_CTRL)
            wr_ok = (addr_r >= ADDR_PROT_LO) && (addr_r <= ADDR_PROT_HI);
        if (addr_r >= ADDR_USER_LO && addr_r <= ADDR_USER_HI && !unlocked_r)
            wr_ok = 1'b0;
        if (addr_r == ADDR_FAULT_FLAGS || (addr_r >= ADDR_DETAIL_LO && addr_r <= ADDR_DETAIL_HI))
            wr_ok = 1'b0;  // Read-only; a fault_flags write clears flags instead
    end
    // Bit and byte framing; select high resets framing and ignores data
    always_ff @(posedge link.sck or posedge link.sel_n) begin
        if (link.sel_n) begin
            bit_cnt_r  <= 3'd0;
            have_cmd_r <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (byte_done)
                have_cmd_r <= 1'b1;
        end
    end
    always_ff @(posedge link.sck) begin
        sh_in_r <= {sh_in_r[5:0], link.mosi};
        if (!link.sel_n && byte_done) begin
            addr_r <= next_addr;
            if (!have_cmd_r)
                is_wr_r <= (rx_byte[DIR_BIT_POS] == DIR_WRITE);
        end
    end
    // Register writes, password tracking and flag clear toggle
    always_ff @(posedge link.sck) begin
        if (!lrst_n) begin
            mask_r     <= 8'h00;
            enable_r   <= ENABLE_RESET;
            range_r    <= 8'h00;
            nvctl_r    <= 8'h00;
            unlocked_r <= 1'b0;
            key_half_r <= 1'b0;
            clr_tgl_r  <= 1'b0;
            clr_bits_r <= 8'h00;
        end else if (!link.sel_n && byte_done && have_cmd_r) begin
            // Any data byte other than the first key breaks the pair
            key_half_r <= 1'b0;
            if (is_wr_r) begin
                if (addr_r == ADDR_UNLOCK_KEY) begin
                    key_half_r <= (rx_byte == KEY_FIRST);
                    unlocked_r <= key_half_r && (rx_byte == KEY_SECOND);
                    if (key_half_r && rx_byte == KEY_SECOND)
                        unlocked_r <= 1'b1;
                    else if (rx_byte != KEY_FIRST)
                        unlocked_r <= 1'b0;
                    else
                        unlocked_r <= unlocked_r;
                end else if (addr_r == ADDR_FAULT_FLAGS) begin
                    clr_bits_r <= rx_byte;   // Write one to clear
                    clr_tgl_r  <= ~clr_tgl_r;
                end else if (wr_ok) begin
                    case (addr_r)
                        ADDR_ENABLE:     enable_r <= rx_byte;
                        ADDR_FAULT_MASK: mask_r   <= rx_byte;
                        ADDR_LINK_RANGE: range_r  <= rx_byte;
                        ADDR_NV_CTRL:    nvctl_r  <= rx_byte;
                        default:         ;
                    endcase
                end
            end
        end
    end
    // Plain storage array, no reset (defaults of plain bytes are zero-free)
    always_ff @(posedge link.sck) begin
        if (!link.sel_n && byte_done && have_cmd_r && is_wr_r && wr_ok && lrst_n)
            mem_r[addr_r] <= rx_byte;
    end
    // Output shifter: loads on the falling edge after the command's last rise, shifts on falling edges
    logic load_r;
    always_ff @(posedge link.sck) begin
        load_r <= !link.sel_n && byte_done && !(have_cmd_r ? is_wr_r : rx_byte[DIR_BIT_POS]);
    end
    always_ff @(negedge link.sck) begin
        if (load_r && bit_cnt_r == 3'd0)
            tx_r <= rd_data;
        else
            tx_r <= {tx_r[6:0], 1'b0};
    end
    assign link.miso_o  = tx_r[7];
    assign link.miso_oe = ~link.sel_n & lrst_n;
    // ------------------------------------------------------------
    // Outputs on clk: interrupt, fast shutdown, control levels
    // ------------------------------------------------------------
    logic [7:0] mask_s1_r, mask_s2_r;
    logic       fsd_s1_r, fsd_s2_r, rng_s1_r, rng_s2_r, prg_s1_r, prg_s2_r;
    always_ff @(posedge clk) begin
        mask_s1_r <= mask_r;
        mask_s2_r <= mask_s1_r;
        fsd_s1_r  <= enable_r[FAST_SD_POS];
        fsd_s2_r  <= fsd_s1_r;
        rng_s1_r  <= range_r[RANGE_SEL_POS];
        rng_s2_r  <= rng_s1_r;
        prg_s1_r  <= nvctl_r[PROGRAM_POS];
        prg_s2_r  <= prg_s1_r;
    end
    // Open-drain style: drive low only while an unmasked flag stands
    assign irq_n_o  = 1'b0;
    assign irq_n_oe = rst_n & |(flags_r & ~mask_s2_r);
    // Only cutoffs, mirror group and light overvoltage trigger it
    always_ff @(posedge clk) begin
        if (!rst_n || !pwr_s2_r)
            fast_shutdown <= 1'b0;
        else
            fast_shutdown <= fsd_s2_r & (fault_in[DF_LOWCUT] | fault_in[DF_THCUT]
                             | mirror_rail_group_error | fault_in[DF_L1_OV] | fault_in[DF_L2_OV]);
    end
    assign link_clock_range_select = rst_n & rng_s2_r;
    assign nv_program = rst_n & prg_s2_r;
endmodule : regport_device
`default_nettype wire

// ### design/regport_host.sv
// Purpose: Host end: serial master issuing one-byte register reads and writes
// Assumes: Link clock derived from clk by a divider
// Notes:   Select held low for the whole command plus data byte
`default_nettype none
module regport_host
    import regport_pkg::*;
(
    // System
    input  wire logic       clk,
    input  wire logic       rst_n,
    // User request
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic       req_write,
    input  wire logic [6:0] req_addr,
    input  wire logic [7:0] req_wdata,
    input  wire logic       fast_range,
    // Answer
    output logic            rsp_valid,
    output logic [7:0]      rsp_rdata,
    // Link
    regport_if.host         link
);
    typedef enum logic [1:0] {IDLE, SHIFT, DONE} hstate_t;
    hstate_t     st_r;
    logic [15:0] out_r;        // Command then data, MSB first
    logic [7:0]  in_r;
    logic [4:0]  bits_r;       // Rising edges left
    logic [1:0]  div_r;
    logic        sck_r;
    logic [1:0]  half;
    assign half = fast_range ? 2'(SCK_HALF_FAST) : 2'(SCK_HALF_NORMAL);
    // Data in moves on our own sck fall, so it is already on clk; a synchroniser would lag a bit
    // Framing: select stays low from first bit to last
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r      <= IDLE;
            sck_r     <= 1'b0;
            div_r     <= 2'd0;
            bits_r    <= 5'd0;
            out_r     <= 16'h0000;
            in_r      <= 8'h00;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            case (st_r)
                IDLE: begin
                    if (req_valid) begin
                        out_r  <= {req_write, req_addr, req_wdata};
                        bits_r <= 5'd16;
                        div_r  <= 2'd0;
                        st_r   <= SHIFT;
                    end
                end
                SHIFT: begin
                    if (div_r + 2'd1 >= half) begin
                        div_r <= 2'd0;
                        sck_r <= ~sck_r;
                        if (!sck_r) begin
                            in_r   <= {in_r[6:0], link.miso};
                            bits_r <= bits_r - 5'd1;
                        end else begin
                            out_r <= {out_r[14:0], 1'b0};
                            if (bits_r == 5'd0)
                                st_r <= DONE;
                        end
                    end else begin
                        div_r <= div_r + 2'd1;
                    end
                end
                DONE: begin
                    rsp_valid <= 1'b1;
                    rsp_rdata <= in_r;
                    st_r      <= IDLE;
                end
                default: st_r <= IDLE;
            endcase
        end
    end
    assign req_ready  = (st_r == IDLE);
    assign link.sck   = sck_r;
    assign link.sel_n = (st_r != SHIFT);
    assign link.mosi  = out_r[15];
endmodule : regport_host
`default_nettype wire

// ### testbench/regport_asserts.sv
// Purpose: Checks on the serial link between host and device ends
// Assumes: sck is made from clk, so clk sees every link edge
// Notes:   Rise counter frames each transfer; reads drive bits 8 to 15
`default_nettype none
module regport_asserts (
    // Domain
    input wire logic clk,
    input wire logic rst_n,
    // Link
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [4:0] rises_r;  // Link clock rises in this frame
    logic       dir_r;    // Direction taken from the first bit
    // Counter clears between frames so a short frame cannot hide
    always_ff @(posedge clk) begin
        if (!rst_n || sel_n) begin
            rises_r <= 5'h0;
        end else if ($rose(sck)) begin
            rises_r <= rises_r + 5'h1;
        end
    end
    // First bit of the command byte gives the direction
    always_ff @(posedge clk) begin
        if ($rose(sck) && rises_r == 5'h0) begin
            dir_r <= mosi;
        end
    end
    chk_idle_float: assert property (sel_n && $past(sel_n) |-> !miso_oe)
        else $error("data out driven while idle");
    chk_mosi_low: assert property (!sel_n && $changed(mosi) |-> !sck)
        else $error("host data moved while clock high");
    chk_miso_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck)
        else $error("device data moved while clock high");
    chk_sck_still: assert property (sel_n && $past(sel_n) |-> !sck)
        else $error("link clock high outside frame");
    chk_frame_bits: assert property ($rose(sel_n) |-> rises_r == 5'd16)
        else $error("frame is not sixteen bits");
    chk_frame_span: assert property ($fell(sel_n) |-> ##[30:200] $rose(sel_n))
        else $error("frame length out of range");
    chk_read_drive: assert property ($rose(sck) && !sel_n && rises_r >= 5'd8 && !dir_r |-> miso_oe)
        else $error("read data not driven");
    chk_rise_framed: assert property ($rose(sck) |-> !sel_n)
        else $error("clock rise without select");
    cover property ($rose(sel_n) && !dir_r);
    cover property ($rose(sel_n) && dir_r);
    cover property ($fell(miso_oe));
endmodule : regport_asserts
`default_nettype wire

// ### testbench/test_spi_register_port_fault_control.sv
// Purpose: Runs host and device end to end against a register copy
// Assumes: Host sends one data byte per frame, so no bursts here
// Notes:   Flag reads are doubled since flags cross into the link domain
`default_nettype none
module test_spi_register_port_fault_control import regport_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, rst_n = 0, pwr_pin = 0, req_valid = 0, req_write = 0, fast = 0;
    logic        req_ready, rsp_valid, irq_n_o, irq_n_oe, fast_sd, norm_sd, range_sel, nv_prog, seen;
    logic [6:0]  req_addr = 7'h0;
    logic [7:0]  req_wdata = 8'h0, rsp_rdata, got;
    logic [17:0] fault_in = 18'h0;
    logic [7:0]  mem [128];  // Expected register contents
    logic [15:0] seed = 16'd13894;
    int          n_errors = 0, n_tests = 0, cyc = 0;
    regport_if link ();
    regport_host i_regport_host (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .fast_range(fast),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .link(link.host));
    regport_device i_regport_device (.clk(clk), .rst_n(rst_n), .link(link.device), .power_request_pin(pwr_pin),
        .fault_in(fault_in), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .fast_shutdown(fast_sd),
        .normal_shutdown(norm_sd), .link_clock_range_select(range_sel), .nv_program(nv_prog));
    regport_asserts i_regport_asserts (.clk(clk), .rst_n(rst_n), .sck(link.sck), .sel_n(link.sel_n),
        .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe));
    always #20 clk = ~clk;
    // Hang guard, well above the roughly 5000 cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors = n_errors + 1;
            give_verdict();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen_v);
        n_tests++;
        if (seen_v !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen_v);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    // Request held until ready is seen high at an edge
    task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
        int k;
        tick(1);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        do @(posedge clk); while (req_ready !== 1'b1);
        #2;
        req_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        got = rsp_rdata;
        cmp("answer", 8'h1, {7'h0, rsp_valid});
    endtask : xfer
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic ok);
        xfer(1'b1, a, d);
        if (ok) mem[a] = d;
    endtask : wr
    task automatic rd(input logic [6:0] a);
        xfer(1'b0, a, 8'h00);
        cmp($sformatf("reg %h", a), mem[a], got);
    endtask : rd
    task automatic give_verdict();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    initial begin
        int         fsrc [9] = '{0, 8, 9, 10, 11, 14, 15, 16, 17};
        logic [7:0] fexp [9] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h08, 8'h10, 8'h60};
        tick(6);
        rst_n = 1'b1;
        wr(ADDR_FAULT_MASK, 8'h00, 1'b1);  // Deaf frame clocks the link reset in
        pwr_pin = 1'b1;
        tick(4);
        wr(ADDR_FAULT_MASK, 8'h00, 1'b1);  // Wakes the link side
        mem[ADDR_ENABLE] = ENABLE_RESET;
        rd(ADDR_ENABLE);
        fault_in[DF_L1_PG] = 1'b1;
        tick(8);
        cmp("fast_sd", 8'h0, {7'h0, fast_sd});
        fault_in[DF_L1_OV] = 1'b1;
        tick(8);
        cmp("fast_sd", 8'h1, {7'h0, fast_sd});
        fault_in = 18'h0;
        tick(4);
        wr(ADDR_FAULT_FLAGS, 8'hff, 1'b0);
        for (int i = 0; i < 10; i++) begin
            if (i == 9) wr(ADDR_FAULT_MASK, 8'hff, 1'b1);
            fault_in = 18'h1 << fsrc[i % 9];
            tick(4);
            mem[ADDR_FAULT_FLAGS] = fexp[i % 9];
            xfer(1'b0, ADDR_FAULT_FLAGS, 8'h00);
            rd(ADDR_FAULT_FLAGS);
            tick(8);
            cmp("irq", {7'h0, i < 9}, {7'h0, irq_n_oe});
            fault_in = 18'h0;
            tick(4);
            wr(ADDR_FAULT_FLAGS, 8'hff, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(ADDR_PROT_LO + 7'h3, seed[15:8], 1'b1);
            wr(ADDR_FAULT_MASK, seed[7:0], i < 3);
            if (i == 2) wr(ADDR_NV_CTRL, 8'h01, 1'b0);
            rd(ADDR_FAULT_MASK);
            rd(ADDR_PROT_LO + 7'h3);
        end
        wr(ADDR_NV_CTRL, 8'h00, 1'b0);
        mem[ADDR_UNLOCK_KEY] = KEY_LOCKED_RD;
        wr(ADDR_UNLOCK_KEY, KEY_FIRST, 1'b0);
        rd(ADDR_UNLOCK_KEY);
        wr(ADDR_UNLOCK_KEY, KEY_SECOND, 1'b0);
        rd(ADDR_UNLOCK_KEY);
        wr(ADDR_UNLOCK_KEY, KEY_FIRST, 1'b0);
        wr(ADDR_UNLOCK_KEY, KEY_SECOND, 1'b0);
        mem[ADDR_UNLOCK_KEY] = KEY_UNLOCKED_RD;
        rd(ADDR_UNLOCK_KEY);
        wr(7'h33, seed[7:0], 1'b1);
        rd(7'h33);
        wr(ADDR_UNLOCK_KEY, 8'h11, 1'b0);
        mem[ADDR_UNLOCK_KEY] = KEY_LOCKED_RD;
        rd(ADDR_UNLOCK_KEY);
        wr(7'h33, ~seed[7:0], 1'b0);
        rd(7'h33);
        fast = 1'b1;
        wr(ADDR_LINK_RANGE, 8'h01, 1'b1);
        tick(8);
        cmp("range", 8'h1, {7'h0, range_sel});
        rd(ADDR_FAULT_MASK);
        wr(ADDR_NV_CTRL, 8'h02, 1'b0);
        tick(8);
        cmp("program", 8'h1, {7'h0, nv_prog});
        wr(ADDR_NV_CTRL, 8'h00, 1'b0);
        tick(8);
        cmp("program", 8'h0, {7'h0, nv_prog});
        fast = 1'b0;
        wr(ADDR_ENABLE, 8'h02, 1'b1);
        pwr_pin = 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 20; i++) begin
            tick(1);
            if (norm_sd === 1'b1) seen = 1'b1;
        end
        cmp("shutdown", 8'h1, {7'h0, seen});
        wr(ADDR_FAULT_MASK, 8'h00, 1'b1);  // Deaf frame resets the registers
        mem[ADDR_ENABLE] = ENABLE_RESET;
        pwr_pin = 1'b1;
        tick(4);
        wr(ADDR_FAULT_MASK, 8'h00, 1'b1);
        rd(ADDR_ENABLE);
        rd(ADDR_UNLOCK_KEY);
        give_verdict();
    end
endmodule : test_spi_register_port_fault_control
`default_nettype wire
